// ---- src/rab_pkg.sv ----
package rab_pkg;
	// region boundaries of the fixed default map
	localparam logic [31:0] RAB_SRAM_BASE = 32'h2000_0000;
	localparam logic [31:0] RAB_PERI_BASE = 32'h4000_0000;
	localparam logic [31:0] RAB_EXTRAM_BASE = 32'h6000_0000;
	localparam logic [31:0] RAB_EXTDEV_BASE = 32'ha000_0000;
	localparam logic [31:0] RAB_PPB_BASE = 32'he000_0000;
	localparam logic [31:0] RAB_RSVD_BASE = 32'he010_0000;
	// bit-band targets and their alias windows
	localparam logic [31:0] RAB_SRAM_BB_BASE = 32'h2000_0000;
	localparam logic [31:0] RAB_SRAM_BB_END = 32'h2001_ffff;
	localparam logic [31:0] RAB_SRAM_ALIAS_BASE = 32'h2200_0000;
	localparam logic [31:0] RAB_SRAM_ALIAS_END = 32'h222f_ffff;
	localparam logic [31:0] RAB_PERI_BB_BASE = 32'h4000_0000;
	localparam logic [31:0] RAB_PERI_BB_END = 32'h400f_ffff;
	localparam logic [31:0] RAB_PERI_ALIAS_BASE = 32'h4200_0000;
	localparam logic [31:0] RAB_PERI_ALIAS_END = 32'h43ff_ffff;
	// alias offset layout: byte offset from bit 5 up, bit number in bits 4:2
	localparam int RAB_ALIAS_BYTE_LSB = 5;
	localparam int RAB_ALIAS_BIT_LSB = 2;
	// access sizes
	localparam logic [1:0] RAB_SZ_BYTE = 2'h0;
	localparam logic [1:0] RAB_SZ_HALF = 2'h1;
	localparam logic [1:0] RAB_SZ_WORD = 2'h2;
	// posted writes that may be in flight at once
	localparam logic [2:0] RAB_POST_MAX = 3'h4;

	typedef enum logic [1:0] {RAB_MT_NORMAL, RAB_MT_DEVICE, RAB_MT_STRONG} rab_mtype_t;
	typedef enum logic [2:0] {
		RAB_OP_READ, RAB_OP_WRITE, RAB_OP_FETCH,
		RAB_OP_DATA_ORDER_BARRIER, RAB_OP_DATA_SYNC_BARRIER, RAB_OP_INSTRUCTION_SYNC_BARRIER
	} rab_op_t;

	typedef struct packed {
		logic valid;
		rab_op_t op;
		logic [31:0] addr;
		logic [1:0] size;
		logic [31:0] wdata;
	} rab_req_t;

	typedef struct packed {
		logic valid;
		logic err;
		logic no_execute_attribute;
		logic [31:0] rdata;
	} rab_rsp_t;

	typedef struct packed {
		rab_mtype_t mtype;
		logic no_execute_attribute;
		logic reserved;
		logic sram_alias;
		logic peri_alias;
	} rab_attr_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic lock;
		logic bufferable;
		logic [1:0] size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} rab_tgt_t;

	// byte address of the target bit for an alias address
	function automatic logic [31:0] rab_alias_target(input logic [31:0] addr,
			input logic [31:0] alias_base, input logic [31:0] tgt_base);
		logic [31:0] off;
		off = addr - alias_base;
		return tgt_base + (off >> RAB_ALIAS_BYTE_LSB);
	endfunction

	// align an address down to the access size
	function automatic logic [31:0] rab_align(input logic [31:0] addr, input logic [1:0] size);
		logic [31:0] a;
		a = addr;
		if (size == RAB_SZ_HALF) a = {addr[31:1], 1'h0};
		else if (size == RAB_SZ_WORD) a = {addr[31:2], 2'h0};
		return a;
	endfunction
endpackage

// ---- src/rab_region_dec.sv ----
`timescale 1ns/100ps
// default attribute decode of one address
module rab_region_dec import rab_pkg::*; (
	input wire logic [31:0] i_addr,
	output wire rab_attr_t o_attr
);
	wire in_code = i_addr < RAB_SRAM_BASE;
	wire in_sram = !in_code && i_addr < RAB_PERI_BASE;
	wire in_peri = i_addr >= RAB_PERI_BASE && i_addr < RAB_EXTRAM_BASE;
	wire in_extram = i_addr >= RAB_EXTRAM_BASE && i_addr < RAB_EXTDEV_BASE;
	wire in_extdev = i_addr >= RAB_EXTDEV_BASE && i_addr < RAB_PPB_BASE;
	wire in_rsvd = i_addr >= RAB_RSVD_BASE;

	// memory type per region; the reserved top is treated as ordered and faults anyway
	assign o_attr.mtype = (in_code || in_sram || in_extram) ? RAB_MT_NORMAL :
		(in_peri || in_extdev) ? RAB_MT_DEVICE : RAB_MT_STRONG;
	assign o_attr.no_execute_attribute = !(in_code || in_sram || in_extram);
	assign o_attr.reserved = in_rsvd;
	// alias windows of the two bit-band targets
	assign o_attr.sram_alias = i_addr >= RAB_SRAM_ALIAS_BASE && i_addr <= RAB_SRAM_ALIAS_END;
	assign o_attr.peri_alias = i_addr >= RAB_PERI_ALIAS_BASE && i_addr <= RAB_PERI_ALIAS_END;
endmodule // rab_region_dec

// ---- src/rab_region_attr_bitband_remap.sv ----
`timescale 1ns/100ps
// Notes on behaviour
// - normal memory may be reordered and read speculatively
// - device accesses stay in order with other device and ordered accesses
// - strongly ordered accesses stay in order with every access
// - device writes may be posted; strongly ordered writes never are
// - fetches from no-execute regions are blocked; fault only on execution
// - earlier device or ordered access is observed before a later one
// - from zero to sram base is code: normal, executable
// - 0x2000_0000 to 0x3fff_ffff is sram: normal, executable
// - from 0x4000_0000 is peripheral: device, no-execute
// - 0x6000_0000 to 0x9fff_ffff is external ram: normal, executable
// - 0xa000_0000 to 0xdfff_ffff is external device: device, no-execute
// - 0xe000_0000 to 0xe00f_ffff ordered, no-execute; above is reserved
// - bit-band targets: sram lowest 128 kb with 3 mb alias, peripheral lowest 1 mb with 32 mb alias; one word per bit
// - sram target and alias windows; direct target access is plain sram
// - sram alias data is remapped; sram alias fetches are not
// - peripheral target and alias windows; peripheral alias fetches refused
// - alias write is atomic read-modify-write of only the addressed bit
// - alias offset equals byte offset times 32 plus bit times 4
// - alias access size is kept for the target access
// - only bit 0 of alias write data sets or clears the bit
// - alias read returns 0 or 1 from the target bit
// - barriers hold later accesses or execution until all complete
// - reserved address access ends in a bus fault
module rab_region_attr_bitband_remap import rab_pkg::*; (
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic i_ce,
	input wire rab_req_t i_req,
	output logic o_req_ready,
	output rab_rsp_t o_rsp,
	output rab_attr_t o_attr,
	output rab_tgt_t o_tgt,
	input wire logic i_tgt_ready,
	input wire logic i_tgt_done,
	input wire logic i_tgt_err,
	input wire logic [31:0] i_tgt_rdata,
	input wire logic i_exec_xn,
	output logic o_xn_fault,
	output logic o_exec_hold,
	output logic o_posted_err
);
	typedef enum logic [1:0] {ST_IDLE, ST_DRAIN, ST_ISSUE, ST_WAIT} rab_state_t;

	rab_state_t state_q;
	rab_req_t cur_q;
	rab_attr_t attr_q;
	rab_rsp_t rsp_q;
	rab_tgt_t tgt_q;
	logic ready_q;
	logic hold_q;
	logic xnf_q;
	logic perr_q;
	logic alias_q;
	logic post_q;
	logic rmw_q;
	logic [4:0] bitpos_q;
	logic [2:0] outst_q;
	rab_attr_t attr_w;

	rab_region_dec u_dec (
		.i_addr(i_req.addr),
		.o_attr(attr_w)
	);

	// classification of the offered request
	wire is_data = i_req.op == RAB_OP_READ || i_req.op == RAB_OP_WRITE;
	wire is_write = i_req.op == RAB_OP_WRITE;
	wire is_fetch = i_req.op == RAB_OP_FETCH;
	wire is_sync = i_req.op == RAB_OP_DATA_SYNC_BARRIER ||
		i_req.op == RAB_OP_INSTRUCTION_SYNC_BARRIER;
	wire is_bar = is_sync || i_req.op == RAB_OP_DATA_ORDER_BARRIER;
	wire strong_w = attr_w.mtype == RAB_MT_STRONG;
	wire take_w = i_req.valid && ready_q;

	// only data accesses are remapped; an sram alias fetch goes out untouched
	wire alias_hit = is_data && (attr_w.sram_alias || attr_w.peri_alias);
	wire [31:0] tgt_byte = attr_w.sram_alias ?
		rab_alias_target(i_req.addr, RAB_SRAM_ALIAS_BASE, RAB_SRAM_BB_BASE) :
		rab_alias_target(i_req.addr, RAB_PERI_ALIAS_BASE, RAB_PERI_BB_BASE);
	// bit lane on the 32-bit data bus: byte lane times 8 plus bit number
	wire [4:0] bitpos_w = {tgt_byte[1:0], i_req.addr[RAB_ALIAS_BIT_LSB +: 3]};
	// same size as the alias access, aligned to it
	wire [31:0] phys_w = rab_align(alias_hit ? tgt_byte : i_req.addr, i_req.size);

	// refused accesses answer at once without reaching a target
	wire fault_w = !is_bar && (attr_w.reserved || (is_fetch && attr_w.peri_alias));
	wire xn_block_w = is_fetch && attr_w.no_execute_attribute && !fault_w;
	// writes that need no completion before answering; ordered ones never qualify
	wire post_w = is_write && !strong_w && !alias_hit;
	wire full_w = outst_q == RAB_POST_MAX;
	// ordered accesses and barriers wait until every posted write has landed
	wire drain_w = is_bar || strong_w || (post_w && full_w);

	// posted write bookkeeping; the target completes strictly in issue order
	wire inc_w = state_q == ST_ISSUE && i_tgt_ready && post_q;
	wire dec_w = i_tgt_done && outst_q != 3'h0;
	wire done_cur = i_tgt_done && outst_q == 3'h0;
	wire [2:0] outst_d = outst_q + {2'h0, inc_w} - {2'h0, dec_w};

	// second phase of an alias write: merge bit 0 of the data into the read word
	wire [31:0] bit_mask = 32'h1 << bitpos_q;
	wire [31:0] merged_w = cur_q.wdata[0] ? (i_tgt_rdata | bit_mask) :
		(i_tgt_rdata & ~bit_mask);
	wire [31:0] alias_rd_w = {31'h0, i_tgt_rdata[bitpos_q]};
	wire rmw_next = cur_q.op == RAB_OP_WRITE && alias_q && !rmw_q;

	// posted-write count and status pulses kept apart from the sequencer
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			outst_q <= 3'h0;
			xnf_q <= 1'h0;
			perr_q <= 1'h0;
		end else if (i_ce) begin
			outst_q <= outst_d;
			xnf_q <= i_exec_xn;
			perr_q <= dec_w && i_tgt_err; // posted writes can only report late
		end
	end

	// request sequencer: one request taken at a time to keep issue order simple
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			state_q <= ST_IDLE;
			cur_q <= '0;
			attr_q <= '0;
			rsp_q <= '0;
			tgt_q <= '0;
			ready_q <= 1'h0;
			hold_q <= 1'h0;
			alias_q <= 1'h0;
			post_q <= 1'h0;
			rmw_q <= 1'h0;
			bitpos_q <= 5'h0;
		end else if (i_ce) begin
			rsp_q.valid <= 1'h0;
			unique case (state_q)
				ST_IDLE: begin
					ready_q <= 1'h1;
					if (take_w) begin
						cur_q <= i_req;
						attr_q <= attr_w;
						alias_q <= alias_hit;
						post_q <= post_w;
						rmw_q <= 1'h0;
						bitpos_q <= bitpos_w;
						if (fault_w || xn_block_w) begin
							rsp_q <= '{valid: 1'h1, err: fault_w,
								no_execute_attribute: xn_block_w, rdata: 32'h0};
						end else begin
							ready_q <= 1'h0;
							hold_q <= is_sync;
							tgt_q.valid <= !drain_w;
							tgt_q.write <= is_write && !alias_hit;
							tgt_q.lock <= alias_hit && is_write;
							tgt_q.bufferable <= post_w;
							tgt_q.size <= i_req.size;
							tgt_q.addr <= phys_w;
							tgt_q.wdata <= i_req.wdata;
							state_q <= drain_w ? ST_DRAIN : ST_ISSUE;
						end
					end
				end
				ST_DRAIN: begin
					if (outst_q == 3'h0) begin
						if (cur_q.op == RAB_OP_READ || cur_q.op == RAB_OP_WRITE ||
								cur_q.op == RAB_OP_FETCH) begin
							tgt_q.valid <= 1'h1;
							state_q <= ST_ISSUE;
						end else begin
							rsp_q <= '{valid: 1'h1, err: 1'h0,
								no_execute_attribute: 1'h0, rdata: 32'h0};
							hold_q <= 1'h0;
							ready_q <= 1'h1;
							state_q <= ST_IDLE;
						end
					end
				end
				ST_ISSUE: begin
					// issue in acceptance order keeps device accesses ordered
					if (i_tgt_ready) begin
						tgt_q.valid <= 1'h0;
						if (post_q) begin
							rsp_q <= '{valid: 1'h1, err: 1'h0,
								no_execute_attribute: 1'h0, rdata: 32'h0};
							ready_q <= 1'h1;
							state_q <= ST_IDLE;
						end else begin
							state_q <= ST_WAIT;
						end
					end
				end
				ST_WAIT: begin
					if (done_cur) begin
						if (rmw_next && !i_tgt_err) begin
							// lock stays up so nothing slips between read and write
							rmw_q <= 1'h1;
							tgt_q.valid <= 1'h1;
							tgt_q.write <= 1'h1;
							tgt_q.wdata <= merged_w;
							state_q <= ST_ISSUE;
						end else begin
							// an alias write answers zero, or the bit if its read failed; an alias read answers the bit
							rsp_q <= '{valid: 1'h1, err: i_tgt_err, no_execute_attribute: 1'h0,
								rdata: rmw_q ? 32'h0 :
								(alias_q ? alias_rd_w : i_tgt_rdata)};
							tgt_q.lock <= 1'h0;
							ready_q <= 1'h1;
							state_q <= ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	assign o_req_ready = ready_q;
	assign o_rsp = rsp_q;
	assign o_attr = attr_q;
	assign o_tgt = tgt_q;
	assign o_xn_fault = xnf_q;
	assign o_exec_hold = hold_q;
	assign o_posted_err = perr_q;
endmodule // rab_region_attr_bitband_remap

// ---- verif/rab_tgt_model.sv ----
`timescale 1ns/100ps
// memory behind the remapper; slow stretches the done latency to test draining
module rab_tgt_model import rab_pkg::*; (
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire rab_tgt_t i_tgt,
	input wire logic i_slow,
	output logic o_ready,
	output logic o_done,
	output logic [31:0] o_rdata = '0,
	output rab_tgt_t o_last = '0
);
	logic [31:0] mem [logic [31:0]];
	logic [31:0] pq [$];
	logic [31:0] w, m;
	int d;
	// dones leave in acceptance order; idle rdata flips so stale data never looks valid
	always @(posedge i_mclk) begin
		o_done <= 1'b0;
		o_rdata <= ~o_rdata;
		if (!i_nrst) begin
			o_ready <= 1'b0;
			pq.delete();
			d = 0;
		end else begin
			o_ready <= i_tgt.valid && !o_ready;
			if (o_ready && i_tgt.valid) begin
				w = {i_tgt.addr[31:2], 2'h0};
				m = (i_tgt.size == RAB_SZ_WORD) ? 32'hffff_ffff :
					(i_tgt.size == RAB_SZ_HALF) ? 32'hffff << {i_tgt.addr[1], 4'h0} :
					32'hff << {i_tgt.addr[1:0], 3'h0};
				if (!mem.exists(w)) mem[w] = '0;
				if (i_tgt.write) mem[w] = (mem[w] & ~m) | (i_tgt.wdata & m);
				pq.push_back(i_tgt.write ? 32'h0 : mem[w]);
				o_last <= i_tgt;
			end
			if (d > 0) d = d - 1;
			else if (pq.size() > 0) begin
				o_done <= 1'b1;
				o_rdata <= pq.pop_front();
				d = i_slow ? 8 : 1;
			end
		end
	end
endmodule // rab_tgt_model

// ---- verif/rab_checker.sv ----
`timescale 1ns/100ps
module rab_checker import rab_pkg::*; (
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic i_ce,
	input wire rab_req_t i_req,
	input wire logic o_req_ready,
	input wire rab_rsp_t o_rsp,
	input wire rab_attr_t o_attr,
	input wire rab_tgt_t o_tgt,
	input wire logic i_tgt_ready,
	input wire logic i_exec_xn,
	input wire logic o_xn_fault
);
	// taken requests, split into data accesses and fetches
	wire take = i_ce && i_req.valid && o_req_ready;
	wire acc = take && (i_req.op == RAB_OP_READ || i_req.op == RAB_OP_WRITE);
	wire ftc = take && (i_req.op == RAB_OP_FETCH);
	wire [31:0] a = i_req.addr;
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);
	a_code_normal: assert property (acc && a < RAB_SRAM_BASE |=> o_attr.mtype == RAB_MT_NORMAL && !o_attr.no_execute_attribute) else $error("code decode wrong");
	a_extdev_device: assert property (acc && a >= RAB_EXTDEV_BASE && a < RAB_PPB_BASE |=> o_attr.mtype == RAB_MT_DEVICE && o_attr.no_execute_attribute) else $error("ext device decode wrong");
	a_ppb_strong: assert property (acc && a >= RAB_PPB_BASE && a < RAB_RSVD_BASE |=> o_attr.mtype == RAB_MT_STRONG && o_attr.no_execute_attribute) else $error("ppb decode wrong");
	a_reserved_fault: assert property (acc && a >= RAB_RSVD_BASE |=> o_rsp.valid && o_rsp.err) else $error("reserved access not faulted");
	a_xn_fetch_block: assert property (ftc && a >= RAB_EXTDEV_BASE && a < RAB_PPB_BASE |=> o_rsp.valid && o_rsp.no_execute_attribute && !o_tgt.valid) else $error("xn fetch not blocked");
	a_peri_alias_fetch: assert property (ftc && a >= RAB_PERI_ALIAS_BASE && a <= RAB_PERI_ALIAS_END |=> o_rsp.valid && o_rsp.err) else $error("alias fetch allowed");
	a_strong_unposted: assert property (o_tgt.valid && o_tgt.addr >= RAB_PPB_BASE && o_tgt.addr < RAB_RSVD_BASE |-> !o_tgt.bufferable) else $error("ordered write posted");
	a_tgt_held: assert property (o_tgt.valid && !i_tgt_ready |=> o_tgt.valid && $stable(o_tgt)) else $error("target request changed");
	a_fault_delay: assert property (i_ce && i_exec_xn |=> o_xn_fault) else $error("execute fault missing");
endmodule // rab_checker
bind rab_region_attr_bitband_remap rab_checker u_rab_checker (.i_mclk(i_mclk), .i_nrst(i_nrst),
	.i_ce(i_ce), .i_req(i_req), .o_req_ready(o_req_ready), .o_rsp(o_rsp), .o_attr(o_attr),
	.o_tgt(o_tgt), .i_tgt_ready(i_tgt_ready), .i_exec_xn(i_exec_xn), .o_xn_fault(o_xn_fault));

// ---- verif/tb_top.sv ----
`timescale 1ns/100ps
module tb_top import rab_pkg::*; ;
	logic i_mclk = 0, i_nrst = 0, i_exec_xn = 0, slow = 0, seen;
	rab_req_t i_req = '0;
	rab_rsp_t o_rsp, r;
	rab_attr_t o_attr;
	rab_tgt_t o_tgt, last;
	logic o_req_ready, t_rdy, t_done, o_xn_fault, o_exec_hold, p_err;
	logic [31:0] t_rdata;
	int num_errors = 0, check_count = 0;
	always #2 i_mclk = ~i_mclk;
	// clock enable stays high: freezing is not exercised here
	rab_region_attr_bitband_remap u_rab_region_attr_bitband_remap (.i_mclk(i_mclk),
		.i_nrst(i_nrst), .i_ce(1'b1), .i_req(i_req), .o_req_ready(o_req_ready), .o_rsp(o_rsp),
		.o_attr(o_attr), .o_tgt(o_tgt), .i_tgt_ready(t_rdy), .i_tgt_done(t_done),
		.i_tgt_err(1'b0), .i_tgt_rdata(t_rdata), .i_exec_xn(i_exec_xn),
		.o_xn_fault(o_xn_fault), .o_exec_hold(o_exec_hold), .o_posted_err(p_err));
	rab_tgt_model u_rab_tgt_model (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_tgt(o_tgt),
		.i_slow(slow), .o_ready(t_rdy), .o_done(t_done), .o_rdata(t_rdata), .o_last(last));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one request held until taken, then the answer is caught while it stands
	task automatic acc(input rab_op_t op, input logic [31:0] a, input logic [1:0] sz,
			input logic [31:0] wd);
		int n;
		n = 0;
		@(negedge i_mclk);
		i_req <= '{1'b1, op, a, sz, wd};
		@(posedge i_mclk);
		while (o_req_ready !== 1'b1 && n++ < 50) @(posedge i_mclk);
		@(negedge i_mclk);
		i_req.valid <= 1'b0;
		for (n = 0; n < 50 && o_rsp.valid !== 1'b1; n++) @(negedge i_mclk);
		r = o_rsp;
	endtask
	task automatic t_decode();
		logic [31:0] ad [6] = '{32'h0000_1000, 32'h2000_0100, 32'h4000_0100, 32'h6000_0100,
			32'ha000_0100, 32'he000_0100};
		int mt [6] = '{0, 0, 1, 0, 1, 2};
		logic [5:0] xn = 6'h34;
		for (int i = 0; i < 6; i++) begin
			acc(RAB_OP_READ, ad[i], RAB_SZ_WORD, '0);
			check(32'(o_attr.mtype), mt[i]);
			check(32'(o_attr.no_execute_attribute), 32'(xn[i]));
			acc(RAB_OP_FETCH, ad[i], RAB_SZ_WORD, '0);
			check(32'(r.no_execute_attribute), 32'(xn[i]));
		end
		acc(RAB_OP_READ, 32'he010_0000, RAB_SZ_WORD, '0);
		check(32'(r.err), 1);
		acc(RAB_OP_WRITE, 32'hffff_fff0, RAB_SZ_WORD, '0);
		check(32'(r.err), 1);
		acc(RAB_OP_FETCH, 32'h4200_0000, RAB_SZ_WORD, '0);
		check(32'(r.err), 1);
		acc(RAB_OP_FETCH, 32'h2200_0040, RAB_SZ_WORD, '0);
		check(last.addr, 32'h2200_0040);
		$display("test decode done");
	endtask
	task automatic t_bitband();
		acc(RAB_OP_WRITE, 32'h2000_0010, RAB_SZ_WORD, 32'ha5a5_0000);
		acc(RAB_OP_WRITE, 32'h2200_0234, RAB_SZ_WORD, 32'hff);
		check(32'(last.lock), 1);
		acc(RAB_OP_READ, 32'h2000_0010, RAB_SZ_WORD, '0);
		check(r.rdata, 32'ha5a5_2000);
		acc(RAB_OP_READ, 32'h2200_0234, RAB_SZ_WORD, '0);
		check(r.rdata, 32'h1);
		acc(RAB_OP_WRITE, 32'h2200_0234, RAB_SZ_WORD, 32'h0e);
		acc(RAB_OP_READ, 32'h2200_0234, RAB_SZ_BYTE, '0);
		check(r.rdata, 32'h0);
		check(32'(last.size), 32'(RAB_SZ_BYTE));
		check(last.addr, 32'h2000_0011);
		acc(RAB_OP_WRITE, 32'h4200_007c, RAB_SZ_WORD, 32'h01);
		acc(RAB_OP_READ, 32'h4000_0000, RAB_SZ_WORD, '0);
		check(r.rdata, 32'h8000_0000);
		$display("test bitband done");
	endtask
	task automatic t_order();
		slow <= 1'b1;
		acc(RAB_OP_WRITE, 32'ha000_0000, RAB_SZ_WORD, 32'h5);
		check(32'(last.bufferable), 1);
		fork
			acc(RAB_OP_DATA_SYNC_BARRIER, '0, RAB_SZ_WORD, '0);
			begin
				// hold is up from the take until the drain ends, which is short here
				repeat (2) @(negedge i_mclk);
				seen = o_exec_hold;
			end
		join
		check(32'(seen), 1);
		check(32'(o_exec_hold), 0);
		acc(RAB_OP_WRITE, 32'he000_0000, RAB_SZ_WORD, 32'h7);
		check(32'(last.bufferable), 0);
		acc(RAB_OP_READ, 32'ha000_0000, RAB_SZ_WORD, '0);
		check(r.rdata, 32'h5);
		slow <= 1'b0;
		@(negedge i_mclk);
		i_exec_xn <= 1'b1;
		@(negedge i_mclk);
		i_exec_xn <= 1'b0;
		check(32'(o_xn_fault), 1);
		check(32'(p_err), 0);
		$display("test order done");
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// watchdog: the whole run needs a few thousand cycles at most
	initial begin
		#100000;
		num_errors++;
		final_report();
	end
	initial begin
		repeat (5) @(negedge i_mclk);
		i_nrst <= 1'b1;
		repeat (2) @(negedge i_mclk);
		t_decode();
		t_bitband();
		t_order();
		final_report();
	end
endmodule // tb_top
